// ### design/mvf_formatter.sv
// measured value word formatter: ethernet and serial frame builders
`timescale 1ns/1ps
`default_nettype none
// Function
// [R01] frames carry only the values selected for that interface
// [R02] video is 512 pixels, 16-bit words, values 0 to 16383
// [R03] ethernet exposure time is a 32-bit word in 100 ns units
// [R04] serial exposure time is an 18-bit word
// [R05] receiver divides serial exposure by nine on fast variants
// [R06] encoder: 32-bit unsigned on ethernet, low 18 bits on serial
// [R07] value counter: 32-bit unsigned on ethernet, low 18 bits serial
// [R08] time stamp counts microseconds, sent 32-bit on ethernet
// [R09] serial time stamp split into low and high 18-bit words
// [R10] each selected distance sends value plus intensity if selected
// [R11] ethernet distances are signed, 1 nm units
// [R12] intensity word bits 0-10 hold peak intensity, full is 1024
// [R13] bits 16-29 hold dark corrected peak maximum, rest reserved
// [R14] serial sends only lower 10 bits of peak intensity
// [R15] intensity is dark max over saturation minus raw plus dark
// [R16] trigger delta 32/18-bit unsigned, 100 ns, range 0 to 100000
// [R17] thickness differences ordered from distance one onward
// [R18] thickness differences are 32-bit signed, 1 nm units
// [R19] statistics sent as minimum, maximum, then peak-to-peak
// [R20] symmetry: 18 fraction bits on ethernet, 4 on serial
// [R21] serial values are low, middle, high bytes with 2-bit prefixes
// [R22] ethernet words go least significant byte first
module mvf_formatter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire mvf_pkg::mvf_sample_t sample,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire mvf_pkg::mvf_pix_t pix_in,
    input wire logic [25:0] eth_select,
    input wire logic [25:0] serial_output_select,
    output logic [7:0] eth_data,
    output logic eth_valid,
    input wire logic eth_ready,
    output logic [7:0] ser_data,
    output logic ser_valid,
    input wire logic ser_ready
);
    import mvf_pkg::*;

    typedef enum logic [2:0] {E_IDLE, E_SCAN, E_FETCH, E_PIX, E_SEND} mvf_eth_st_t;
    typedef enum logic [1:0] {S_IDLE, S_SCAN, S_SEND} mvf_ser_st_t;

    // intensity word from raw and dark corrected peak maxima
    function automatic logic [31:0] int_word(input logic [13:0] raw, input logic [13:0] dark);
        logic [14:0] den;
        logic [24:0] q;
        den = ADC_SAT - {1'b0, raw} + {1'b0, dark}; // R15
        q = (den == 15'h0) ? INT_FULL : {1'b0, dark, 10'h0} / {10'h0, den}; // R15
        if (q > INT_FULL) begin
            q = INT_FULL;
        end
        return {2'h0, dark, 5'h0, q[10:0]}; // R12 R13
    endfunction

    // full width word of one frame item
    function automatic logic [31:0] item_word(input logic [4:0] idx, input mvf_sample_t s,
                                              input logic [3:0][31:0] iw, input logic [31:0] cnt,
                                              input logic [31:0] ts);
        logic c;
        logic [4:0] sub;
        c = (idx >= IT_CH1);
        sub = idx - (c ? IT_CH1 : IT_CH0);
        item_word = 32'h0;
        if (idx >= IT_CH0 && idx < IT_TRIG) begin
            case (sub)
                SUB_EXP: item_word = s.ch[c].exposure; // R03
                SUB_ENC1: item_word = s.ch[c].enc1; // R06
                SUB_ENC2: item_word = s.ch[c].enc2; // R06
                SUB_INT1: item_word = iw[{c, 1'b0}]; // R10
                SUB_DIST1: item_word = s.ch[c].dist1; // R10 R11
                SUB_INT2: item_word = iw[{c, 1'b1}]; // R10
                SUB_DIST2: item_word = s.ch[c].dist2; // R10 R11
                default: item_word = 32'h0;
            endcase
        end else begin
            case (idx)
                IT_TRIG: item_word = s.trig_delta; // R16
                IT_TS: item_word = ts; // R08
                IT_TSLO: item_word = ts; // R09
                IT_TSHI: item_word = ts >> TS_HI_SHIFT; // R09
                IT_CNT: item_word = cnt; // R07
                IT_THK0: item_word = s.thick[0]; // R17 R18
                IT_THK1: item_word = s.thick[1]; // R17 R18
                IT_SMIN: item_word = s.stat_min; // R19
                IT_SMAX: item_word = s.stat_max; // R19
                IT_SP2P: item_word = s.stat_max - s.stat_min; // R19
                IT_SYM: item_word = s.symmetry; // R20
                default: item_word = 32'h0;
            endcase
        end
    endfunction

    // reduce a word to the 18-bit serial value
    function automatic logic [17:0] ser_word(input logic [4:0] idx, input logic [31:0] w);
        logic [4:0] sub;
        sub = idx - ((idx >= IT_CH1) ? IT_CH1 : IT_CH0);
        if (idx >= IT_CH0 && idx < IT_TRIG && (sub == SUB_INT1 || sub == SUB_INT2)) begin
            ser_word = {8'h0, w[9:0]}; // R14
        end else if (idx == IT_SYM) begin
            ser_word = w[SYM_SHIFT +: SER_W]; // R20
        end else begin
            ser_word = w[SER_W-1:0]; // R04 R05 R06 R07 R16
        end
    endfunction

    mvf_eth_st_t eth_st_ff;
    mvf_ser_st_t ser_st_ff;
    mvf_sample_t snap_ff;
    logic [3:0][31:0] intw_ff;
    logic [31:0] cnt_ff, ts_ff, us_ff;
    logic [6:0] tick_ff;
    logic [25:0] esel_ff, ssel_ff;
    logic [4:0] eidx_ff, sidx_ff;
    logic [8:0] pix_ff;
    logic [31:0] esh_ff;
    logic [2:0] ebcnt_ff;
    logic [23:0] ssh_ff;
    logic [1:0] sbcnt_ff;
    logic sent_any_ff;
    logic [15:0] rd_pix;
    logic capture;
    mvf_pix_t pix_wr;
    logic [31:0] eword, sword;
    logic [17:0] sval;

    assign sample_ready = (eth_st_ff == E_IDLE) && (ser_st_ff == S_IDLE);
    assign capture = sample_valid && sample_ready;
    assign eth_valid = (eth_st_ff == E_SEND);
    assign ser_valid = (ser_st_ff == S_SEND);
    assign eth_data = esh_ff[7:0];
    assign ser_data = ssh_ff[7:0];
    assign eword = item_word(eidx_ff, snap_ff, intw_ff, cnt_ff, ts_ff);
    assign sword = item_word(sidx_ff, snap_ff, intw_ff, cnt_ff, ts_ff);
    assign sval = ser_word(sidx_ff, sword);

    // pixel writes clamped to the converter range
    always_comb begin
        pix_wr = pix_in;
        if (pix_in.data > PIX_MAX) begin
            pix_wr.data = PIX_MAX; // R02
        end
    end

    mvf_pix_mem u_pix_mem (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(pix_wr),
        .rd_addr(pix_ff),
        .rd_data(rd_pix)
    );

    // microsecond time base
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_ff <= 7'h0;
            us_ff <= 32'h0;
        end else if (tick_ff == TICK_CYC - 7'h1) begin
            tick_ff <= 7'h0;
            us_ff <= us_ff + 32'h1; // R08
        end else begin
            tick_ff <= tick_ff + 7'h1;
        end
    end

    // snapshot of one measurement and its selections
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            snap_ff <= '0;
            intw_ff <= '0;
            cnt_ff <= 32'h0;
            ts_ff <= 32'h0;
            esel_ff <= 26'h0;
            ssel_ff <= 26'h0;
        end else if (capture) begin
            snap_ff <= sample;
            if (sample.trig_delta > TRIG_MAX) begin
                snap_ff.trig_delta <= TRIG_MAX; // R16
            end
            for (int c = 0; c < 2; c++) begin
                intw_ff[2*c] <= int_word(sample.ch[c].raw_max1, sample.ch[c].dark_max1); // R15
                intw_ff[2*c+1] <= int_word(sample.ch[c].raw_max2, sample.ch[c].dark_max2); // R15
            end
            cnt_ff <= cnt_ff + 32'h1; // R07
            ts_ff <= us_ff; // R08
            esel_ff <= eth_select & ETH_OK; // R01
            ssel_ff <= serial_output_select & SER_OK; // R01
        end
    end

    // ethernet frame builder
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eth_st_ff <= E_IDLE;
            eidx_ff <= 5'h0;
            pix_ff <= 9'h0;
            esh_ff <= 32'h0;
            ebcnt_ff <= 3'h0;
        end else begin
            case (eth_st_ff)
                E_IDLE: begin
                    if (capture) begin
                        eidx_ff <= 5'h0;
                        eth_st_ff <= E_SCAN;
                    end
                end
                E_SCAN: begin
                    if (eidx_ff == NUM_ITEMS) begin
                        eth_st_ff <= E_IDLE;
                    end else if (!esel_ff[eidx_ff]) begin
                        eidx_ff <= eidx_ff + 5'h1; // R01
                    end else if (eidx_ff == IT_VIDEO) begin
                        pix_ff <= 9'h0;
                        eth_st_ff <= E_FETCH;
                    end else begin
                        esh_ff <= eword;
                        ebcnt_ff <= 3'h4;
                        eth_st_ff <= E_SEND;
                    end
                end
                E_FETCH: eth_st_ff <= E_PIX;
                E_PIX: begin
                    esh_ff <= {16'h0, rd_pix}; // R02
                    ebcnt_ff <= 3'h2;
                    eth_st_ff <= E_SEND;
                end
                E_SEND: begin
                    if (eth_ready) begin
                        esh_ff <= esh_ff >> 8; // R22
                        ebcnt_ff <= ebcnt_ff - 3'h1;
                        if (ebcnt_ff == 3'h1) begin
                            if (eidx_ff == IT_VIDEO && pix_ff != PIX_LAST) begin
                                pix_ff <= pix_ff + 9'h1; // R02
                                eth_st_ff <= E_FETCH;
                            end else begin
                                eidx_ff <= eidx_ff + 5'h1;
                                eth_st_ff <= E_SCAN;
                            end
                        end
                    end
                end
                default: eth_st_ff <= E_IDLE;
            endcase
        end
    end

    // serial frame builder
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ser_st_ff <= S_IDLE;
            sidx_ff <= 5'h0;
            ssh_ff <= 24'h0;
            sbcnt_ff <= 2'h0;
            sent_any_ff <= 1'b0;
        end else begin
            case (ser_st_ff)
                S_IDLE: begin
                    if (capture) begin
                        sidx_ff <= 5'h0;
                        sent_any_ff <= 1'b0;
                        ser_st_ff <= S_SCAN;
                    end
                end
                S_SCAN: begin
                    if (sidx_ff == NUM_ITEMS) begin
                        ser_st_ff <= S_IDLE;
                    end else if (!ssel_ff[sidx_ff]) begin
                        sidx_ff <= sidx_ff + 5'h1; // R01
                    end else begin
                        ssh_ff <= {(sent_any_ff ? PFX_HI_NEXT : PFX_HI_FIRST), sval[17:12],
                                   PFX_MID, sval[11:6], PFX_LO, sval[5:0]}; // R21
                        sbcnt_ff <= 2'h3;
                        ser_st_ff <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (ser_ready) begin
                        ssh_ff <= ssh_ff >> 8; // R21
                        sbcnt_ff <= sbcnt_ff - 2'h1;
                        if (sbcnt_ff == 2'h1) begin
                            sent_any_ff <= 1'b1;
                            sidx_ff <= sidx_ff + 5'h1;
                            ser_st_ff <= S_SCAN;
                        end
                    end
                end
                default: ser_st_ff <= S_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence eth_byte_taken;
        eth_valid && eth_ready && ebcnt_ff > 3'h1;
    endsequence

    sequence ser_value_loaded;
        ser_st_ff == S_SCAN && sidx_ff != NUM_ITEMS && ssel_ff[sidx_ff];
    endsequence

    chk_eth_lsb_first: assert property (eth_byte_taken |=> eth_data == $past(esh_ff[15:8])) // R22
        else $error("ethernet byte order broken");
    chk_eth_only_sel: assert property (eth_valid |-> esel_ff[eidx_ff] && ETH_OK[eidx_ff]) // R01
        else $error("unselected ethernet item sent");
    chk_ser_prefix_order: assert property (ser_value_loaded |=> ser_data[7:6] == PFX_LO) // R21
        else $error("serial low prefix wrong");
    chk_ser_mid_prefix: assert property (ser_valid && ser_ready && sbcnt_ff == 2'h3 |=> ser_data[7:6] == PFX_MID) // R21
        else $error("serial middle prefix wrong");
    chk_ser_hi_prefix: assert property (ser_valid && sbcnt_ff == 2'h1 |->
        ser_data[7:6] == (sent_any_ff ? PFX_HI_NEXT : PFX_HI_FIRST)) // R21
        else $error("serial high prefix wrong");
    chk_pix_range: assert property (eth_st_ff == E_PIX |-> rd_pix <= PIX_MAX ##1 eth_valid) // R02
        else $error("pixel out of range");
    chk_trig_clamp: assert property (capture |=> snap_ff.trig_delta <= TRIG_MAX) // R16
        else $error("trigger delta beyond range");
    chk_int_scale: assert property (capture |=> intw_ff[0][10:0] <= INT_FULL[10:0]
        && intw_ff[0][15:11] == 5'h0 && intw_ff[0][31:30] == 2'h0) // R12 R13
        else $error("intensity word malformed");
    chk_count_step: assert property (capture |=> cnt_ff == $past(cnt_ff) + 32'h1
        && ts_ff == $past(us_ff)) // R07 R08
        else $error("counter or time stamp not taken");
    chk_us_tick: assert property (tick_ff == TICK_CYC - 7'h1 |=> us_ff == $past(us_ff) + 32'h1
        && tick_ff == 7'h0) // R08
        else $error("microsecond tick wrong");
    chk_ser_int_bits: assert property ((ser_value_loaded and (sidx_ff == IT_CH0 + SUB_INT1))
        |=> ssh_ff[23:16] == {PFX_HI_FIRST | {1'b0, sent_any_ff}, 6'h0}) // R14
        else $error("serial intensity above ten bits");
endmodule
`default_nettype wire

// ### design/mvf_pix_mem.sv
// one video line of pixel words with registered read data
`timescale 1ns/1ps
`default_nettype none
module mvf_pix_mem (
    input wire logic clk,
    input wire logic sys_rst,
    input wire mvf_pkg::mvf_pix_t wr,
    input wire logic [8:0] rd_addr,
    output logic [15:0] rd_data
);
    import mvf_pkg::*;

    logic [15:0] mem [0:511];

    // write port
    always_ff @(posedge clk) begin
        if (wr.we) begin
            mem[wr.addr] <= wr.data;
        end
    end

    // registered read port
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 16'h0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ### design/mvf_pkg.sv
// constants and carriers for the measured value word formatter
package mvf_pkg;
    localparam int ITEM_W = 5;
    // frame items in transmit order
    localparam logic [4:0] IT_VIDEO = 5'h00;
    localparam logic [4:0] IT_CH0 = 5'h01;
    localparam logic [4:0] IT_CH1 = 5'h08;
    localparam logic [4:0] CH_ITEMS = 5'h07;
    localparam logic [4:0] IT_TRIG = 5'h0f;
    localparam logic [4:0] IT_TS = 5'h10;
    localparam logic [4:0] IT_TSLO = 5'h11;
    localparam logic [4:0] IT_TSHI = 5'h12;
    localparam logic [4:0] IT_CNT = 5'h13;
    localparam logic [4:0] IT_THK0 = 5'h14;
    localparam logic [4:0] IT_THK1 = 5'h15;
    localparam logic [4:0] IT_SMIN = 5'h16;
    localparam logic [4:0] IT_SMAX = 5'h17;
    localparam logic [4:0] IT_SP2P = 5'h18;
    localparam logic [4:0] IT_SYM = 5'h19;
    localparam logic [4:0] NUM_ITEMS = 5'h1a;
    // per channel sub items
    localparam logic [4:0] SUB_EXP = 5'h00;
    localparam logic [4:0] SUB_ENC1 = 5'h01;
    localparam logic [4:0] SUB_ENC2 = 5'h02;
    localparam logic [4:0] SUB_INT1 = 5'h03;
    localparam logic [4:0] SUB_DIST1 = 5'h04;
    localparam logic [4:0] SUB_INT2 = 5'h05;
    localparam logic [4:0] SUB_DIST2 = 5'h06;
    // which items each interface may carry
    localparam logic [25:0] ETH_OK = ~((26'h1 << IT_TSLO) | (26'h1 << IT_TSHI));
    localparam logic [25:0] SER_OK = ~((26'h1 << IT_VIDEO) | (26'h1 << IT_TS));
    // video
    localparam logic [8:0] PIX_LAST = 9'h1ff;
    localparam logic [15:0] PIX_MAX = 16'h3fff;
    // scaling
    localparam logic [14:0] ADC_SAT = 15'h3fff;
    localparam logic [24:0] INT_FULL = 25'h0000400;
    localparam logic [31:0] TRIG_MAX = 32'h000186a0;
    localparam int SER_W = 18;
    localparam int TS_HI_SHIFT = 18;
    localparam int SYM_SHIFT = 14;
    // serial byte prefixes
    localparam logic [1:0] PFX_LO = 2'h0;
    localparam logic [1:0] PFX_MID = 2'h1;
    localparam logic [1:0] PFX_HI_FIRST = 2'h2;
    localparam logic [1:0] PFX_HI_NEXT = 2'h3;
    // time stamp tick
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1000;
    localparam logic [6:0] TICK_CYC = 7'(TICK_NS / CLK_NS);

    typedef struct packed {
        logic [31:0] exposure;
        logic [31:0] enc1;
        logic [31:0] enc2;
        logic [13:0] raw_max1;
        logic [13:0] dark_max1;
        logic [31:0] dist1;
        logic [13:0] raw_max2;
        logic [13:0] dark_max2;
        logic [31:0] dist2;
    } mvf_chan_t;

    typedef struct packed {
        mvf_chan_t [1:0] ch;
        logic [31:0] trig_delta;
        logic [1:0][31:0] thick;
        logic [31:0] stat_min;
        logic [31:0] stat_max;
        logic [31:0] symmetry;
    } mvf_sample_t;

    typedef struct packed {
        logic we;
        logic [8:0] addr;
        logic [15:0] data;
    } mvf_pix_t;
endpackage

// ### test/mvf_formatter_tb.sv
// self-checking bench for the measured value word formatter
`timescale 1ns/1ps
`default_nettype none
module mvf_formatter_tb;
    import mvf_pkg::*;
    typedef struct {int k; logic [25:0] es; logic [25:0] ss; logic sl;} mvf_row_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    mvf_sample_t sample = '0;
    logic sample_valid = 1'b0;
    logic sample_ready;
    mvf_pix_t pix_in = '0;
    logic [25:0] eth_select = '0;
    logic [25:0] serial_output_select = '0;
    logic [7:0] eth_data;
    logic [7:0] ser_data;
    logic eth_valid;
    logic eth_ready;
    logic ser_valid;
    logic ser_ready;
    logic slow = 1'b0;
    int err_count = 0;
    int checks_done = 0;
    logic [31:0] frames = 32'h0;
    time cap_t = 0;
    time rel_t = 0;
    logic [15:0] pix_exp[512];
    logic [7:0] eq[$];
    logic [7:0] sq[$];
    logic [31:0] w;
    mvf_row_t rows[4] = '{'{32'h0, 26'h3fefffe, 26'h3f9ffff, 1'b0}, '{32'h1, 26'h000ff00, 26'h0002aaa, 1'b1},
                          '{32'h2, 26'h0000000, 26'h1c00000, 1'b0}, '{32'h3, 26'h3300000, 26'h0080000, 1'b1}};

    mvf_formatter mvf_formatter_inst (.clk(clk), .sys_rst(sys_rst), .sample(sample), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .pix_in(pix_in), .eth_select(eth_select),
        .serial_output_select(serial_output_select), .eth_data(eth_data), .eth_valid(eth_valid),
        .eth_ready(eth_ready), .ser_data(ser_data), .ser_valid(ser_valid), .ser_ready(ser_ready));
    mvf_host_sink eth_sink_inst (.clk(clk), .data(eth_data), .valid(eth_valid), .ready(eth_ready), .slow(slow));
    mvf_host_sink ser_sink_inst (.clk(clk), .data(ser_data), .valid(ser_valid), .ready(ser_ready), .slow(slow));

    // free-running clock
    always #5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cmpq(input logic [7:0] got[$], input logic [7:0] ex[$]);
        check(32'(got.size()), 32'(ex.size()));
        foreach (ex[i]) check({24'h0, got[i]}, {24'h0, ex[i]});
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // intensity word from the raw and dark corrected peak maxima
    function automatic logic [31:0] iw(input logic [13:0] r, input logic [13:0] d);
        longint q;
        q = (longint'(d) * 1024) / (longint'(16383) - r + d);
        if (q > 1024) q = 1024;
        return {2'h0, d, 5'h0, 11'(q)};
    endfunction

    // ethernet word of one item
    function automatic logic [31:0] eword(input mvf_sample_t s, input int i, input logic [31:0] cnt);
        int c;
        int u;
        c = (i - 1) / 7;
        u = (i - 1) % 7;
        if (i >= 1 && i <= 14) begin
            case (u)
                0: return s.ch[c].exposure; // raw units, host rescales
                1: return s.ch[c].enc1;
                2: return s.ch[c].enc2;
                3: return iw(s.ch[c].raw_max1, s.ch[c].dark_max1);
                4: return s.ch[c].dist1;
                5: return iw(s.ch[c].raw_max2, s.ch[c].dark_max2);
                default: return s.ch[c].dist2;
            endcase
        end
        case (i)
            15: return (s.trig_delta > 32'h186a0) ? 32'h186a0 : s.trig_delta;
            19: return cnt;
            20: return s.thick[0];
            21: return s.thick[1];
            22: return s.stat_min;
            23: return s.stat_max;
            24: return s.stat_max - s.stat_min;
            default: return s.symmetry;
        endcase
    endfunction

    // serial value of one item
    function automatic logic [17:0] sval(input mvf_sample_t s, input int i, input logic [31:0] cnt);
        logic [31:0] v;
        v = eword(s, i, cnt);
        if (i == 4 || i == 6 || i == 11 || i == 13) return {8'h0, v[9:0]};
        if (i == 25) return v[31:14];
        return v[17:0];
    endfunction

    function automatic mvf_sample_t mk(input int k);
        mvf_sample_t s;
        for (int b = 0; b < $bits(mvf_sample_t); b += 16) s[b +: 16] = 16'(k * 945 + b * 157 + 4951);
        s.trig_delta = (k == 1) ? 32'h186a1 : 32'(k * 1000 + 7);
        if (k == 1) s.ch[1].raw_max1 = 14'h3fff;
        return s;
    endfunction

    // expected byte streams of both interfaces
    task automatic build(input mvf_sample_t s, input logic [25:0] es, input logic [25:0] ss);
        logic [31:0] v;
        logic [17:0] t;
        logic first;
        eq.delete();
        sq.delete();
        first = 1'b1;
        if (es[0]) foreach (pix_exp[i]) begin
            eq.push_back(pix_exp[i][7:0]);
            eq.push_back(pix_exp[i][15:8]);
        end
        for (int i = 1; i < 26; i++) if (es[i] && (i < 16 || i > 18)) begin
            v = eword(s, i, frames);
            for (int b = 0; b < 4; b++) eq.push_back(v[8 * b +: 8]);
        end
        for (int i = 1; i < 26; i++) if (ss[i] && (i < 16 || i > 18)) begin
            t = sval(s, i, frames);
            sq.push_back({2'h0, t[5:0]});
            sq.push_back({2'h1, t[11:6]});
            sq.push_back({first ? 2'h2 : 2'h3, t[17:12]});
            first = 1'b0;
        end
    endtask

    // one capture with a refused request while busy, then wait for both frames
    task automatic run_frame(input mvf_sample_t s, input logic [25:0] es, input logic [25:0] ss, input logic sl);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        eth_sink_inst.got.delete();
        ser_sink_inst.got.delete();
        sample = s;
        eth_select = es;
        serial_output_select = ss;
        slow = sl;
        while (sample_ready !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        sample_valid = 1'b1;
        @(posedge clk);
        cap_t = $time;
        frames++;
        #1 sample_valid = 1'b0;
        @(posedge clk);
        #1 sample_valid = !sample_ready;
        @(posedge clk);
        #1 sample_valid = 1'b0;
        n = 0;
        while (sample_ready !== 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(n < 20000), 32'h1);
        build(s, es, ss);
    endtask

    // cut a hang short
    initial begin
        #500000;
        err_count++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1;
        check({29'h0, sample_ready, eth_valid, ser_valid}, 32'h4);
        sys_rst = 1'b0;
        rel_t = $time;
        foreach (rows[r]) begin
            run_frame(mk(rows[r].k), rows[r].es, rows[r].ss, rows[r].sl);
            cmpq(eth_sink_inst.got, eq);
            cmpq(ser_sink_inst.got, sq);
        end
        // video line with values above the pixel range
        for (int i = 0; i < 512; i++) begin
            @(posedge clk);
            #1 pix_in = '{we: 1'b1, addr: 9'(i), data: 16'(i * 97)};
            pix_exp[i] = (16'(i * 97) > 16'h3fff) ? 16'h3fff : 16'(i * 97);
        end
        @(posedge clk);
        #1 pix_in.we = 1'b0;
        run_frame(mk(4), 26'h0000001, 26'h0000001, 1'b1);
        cmpq(eth_sink_inst.got, eq);
        cmpq(ser_sink_inst.got, sq);
        // time stamp on both interfaces
        run_frame(mk(5), 26'h0010000, 26'h0060000, 1'b0);
        eq = eth_sink_inst.got;
        sq = ser_sink_inst.got;
        w = {eq[3], eq[2], eq[1], eq[0]};
        check(32'(sq.size()), 32'h6);
        check({14'h0, sq[2][5:0], sq[1][5:0], sq[0][5:0]}, {14'h0, w[17:0]});
        check({14'h0, sq[5][5:0], sq[4][5:0], sq[3][5:0]}, {18'h0, w[31:18]});
        check(32'(longint'(w) + 1 >= (cap_t - rel_t) / 1000 && longint'(w) <= (cap_t - rel_t) / 1000 + 1), 32'h1);
        // reset in mid-run restarts the value counter
        @(posedge clk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        rel_t = $time;
        frames = 32'h0;
        run_frame(mk(6), 26'h0080000, 26'h0080000, 1'b0);
        cmpq(eth_sink_inst.got, eq);
        cmpq(ser_sink_inst.got, sq);
        summarize();
    end
endmodule
`default_nettype wire

// ### test/mvf_host_sink.sv
// host model that takes in the bytes of one measurement stream
`timescale 1ns/1ps
`default_nettype none
module mvf_host_sink (
    input wire logic clk,
    input wire logic [7:0] data,
    input wire logic valid,
    output logic ready,
    input wire logic slow
);
    logic [7:0] got[$];
    logic take_ff = 1'b0;
    logic [7:0] held_ff = 8'h00;
    logic [1:0] phase_ff = 2'h0;

    initial begin
        ready = 1'b0;
    end

    // decide acceptance once the stream outputs have settled
    always @(negedge clk) begin
        take_ff = valid && ready;
        held_ff = data;
    end

    // collect the byte at the edge; slow mode stalls half of the cycles
    always @(posedge clk) begin
        if (take_ff) begin
            got.push_back(held_ff);
        end
        phase_ff = phase_ff + 2'h1;
        ready <= #1 !slow || phase_ff[1];
    end
endmodule
`default_nettype wire
